// >>> rtl/psk_tx_host_pkg.sv
// Package for the PSK transmit host controller.
// Holds the modem's register map as seen from outside, our own register map,
// timing figures and the carrier struct for the outgoing serial link pins.
package psk_tx_host_pkg;

  // Clock rate and documented times.
  localparam int CLK_HZ = 20_000_000;
  localparam int WAKE_MS = 20;
  localparam int WAKE_CYCLES = (CLK_HZ / 1000) * WAKE_MS;
  localparam int MS_CYCLES = CLK_HZ / 1000;

  // Serial link: cycles per half period of the serial clock, and bits per frame.
  localparam logic [3:0] LINK_HALF = 4'h4;
  localparam logic [4:0] LINK_BITS = 5'h10;

  // Modem registers reached over the serial link.
  localparam logic [7:0] DEV_SETUP = 8'he0;
  localparam logic [7:0] DEV_GAIN = 8'he2;
  localparam logic [7:0] DEV_TXBYTE = 8'he3;
  localparam logic [7:0] DEV_TXMODE = 8'he7;
  localparam logic [7:0] DEV_TONES = 8'hec;
  localparam logic [7:0] DEV_MASK = 8'hee;
  localparam logic [7:0] DEV_FLAGS = 8'hef;

  // Modem field positions and values.
  localparam int FLAG_TXREADY = 1;
  localparam int FLAG_UNDERFLOW = 2;
  localparam int FLAG_RINGCHG = 6;
  localparam int TONE_RING = 6;
  localparam logic [7:0] MASK_TX = 8'h06;
  localparam logic [7:0] TXMODE_ON = 8'h01;
  localparam logic [7:0] TXMODE_OFF = 8'h00;

  // Our own registers, word index on the software port.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SETUP = 4'h1;
  localparam logic [3:0] REG_GAIN = 4'h2;
  localparam logic [3:0] REG_TXDATA = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_EVENTS = 4'h5;
  localparam logic [3:0] REG_EVCLR = 4'h6;
  localparam logic [3:0] REG_EVEN = 4'h7;
  localparam logic [3:0] REG_RINGTIME = 4'h8;

  // Control bits and event bits.
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_ZEROPWR = 2;
  localparam int EV_TAKEN = 0;
  localparam int EV_UNDERFLOW = 1;
  localparam int EV_RINGEND = 2;
  localparam int EV_STOPPED = 3;

  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] GAIN_RESET = 8'h00;

  typedef struct packed {
    logic serialClk;
    logic selectLow;
    logic cmdData;
  } link_out_t;

endpackage

// >>> rtl/psk_tx_host.sv
// Host controller that runs the modem's PSK transmit sequence.
// Assumes the modem answers a 16-bit serial frame (address byte, then a data
// byte written or read back) and drives an active-low interrupt pin.

//////////////////////////////////////////////////////////////////////////////

module psk_tx_host
  #(
    parameter int WakeCycles = psk_tx_host_pkg::WAKE_CYCLES, // zero-power wait
    parameter int MsCycles = psk_tx_host_pkg::MS_CYCLES // ring timer tick
  )
  (
    input wire logic clk, // 20 MHz clock
    input wire logic rst_b, // async reset, active low
    input wire logic [3:0] addr, // register index
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd
    output logic irq, // level interrupt, active high
    output psk_tx_host_pkg::link_out_t linkOut, // serial link outputs
    input wire logic replyData, // serial reply from modem
    input wire logic interrupt_request_low // modem interrupt, active low
  );
  import psk_tx_host_pkg::*;

  typedef enum {
    S_IDLE, S_WAKE, S_GAIN, S_FIRST, S_CLEAR, S_MASK, S_ENABLE,
    S_WAIT, S_EVAL, S_TONES, S_READY, S_LOAD, S_XFER
  } seq_state_t;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic replyMeta;
  logic replySync;
  logic irqMeta;
  logic irqSync_b;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      replyMeta <= 1'b0;
      replySync <= 1'b0;
      irqMeta <= 1'b1;
      irqSync_b <= 1'b1;
    end
    else
    begin
      replyMeta <= replyData;
      replySync <= replyMeta;
      irqMeta <= interrupt_request_low;
      irqSync_b <= irqMeta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial engine: one address byte then one data byte, MSB first.
  // The reply is sampled at the end of each high phase; the half period of
  // four cycles leaves room for the two-stage synchroniser delay.

  logic xferStart;
  logic [7:0] xferAddr;
  logic [7:0] xferData;
  logic busy;
  logic sclk;
  logic [3:0] halfCnt;
  logic [4:0] bitCnt;
  logic [15:0] shiftOut;
  logic [7:0] rxShift;
  logic xferDone;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy <= 1'b0;
      sclk <= 1'b0;
      halfCnt <= 4'h0;
      bitCnt <= 5'h0;
      shiftOut <= 16'h0000;
      rxShift <= 8'h00;
      xferDone <= 1'b0;
    end
    else
    begin
      xferDone <= 1'b0;
      if (xferStart)
      begin
        busy <= 1'b1;
        sclk <= 1'b0;
        halfCnt <= 4'h0;
        bitCnt <= 5'h0;
        shiftOut <= {xferAddr, xferData};
      end
      else if (busy)
      begin
        if (halfCnt == LINK_HALF - 4'h1)
        begin
          halfCnt <= 4'h0;
          if (!sclk)
          begin
            sclk <= 1'b1;
          end
          else
          begin
            sclk <= 1'b0;
            rxShift <= {rxShift[6:0], replySync};
            shiftOut <= {shiftOut[14:0], 1'b0};
            if (bitCnt == LINK_BITS - 5'h1)
            begin
              busy <= 1'b0;
              xferDone <= 1'b1;
            end
            else
            begin
              bitCnt <= bitCnt + 5'h1;
            end
          end
        end
        else
        begin
          halfCnt <= halfCnt + 4'h1;
        end
      end
    end
  end

  assign linkOut.serialClk = sclk;
  assign linkOut.selectLow = ~busy;
  assign linkOut.cmdData = shiftOut[15];

  //////////////////////////////////////////////////////////////////////////
  // Software registers.

  logic [7:0] setup_reg;
  logic [7:0] gain_reg;
  logic [7:0] txData_reg;
  logic [7:0] evEnable_reg;
  logic zeroPower_reg;
  logic dataValid_reg;
  logic startReq_reg;
  logic stopReq_reg;
  logic byteTaken;
  logic startTaken;
  logic stopTaken;
  logic wrCtrl;

  assign wrCtrl = wr && addr == REG_CTRL;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      setup_reg <= SETUP_RESET;
      gain_reg <= GAIN_RESET;
      txData_reg <= 8'h00;
      evEnable_reg <= 8'h00;
      zeroPower_reg <= 1'b0;
    end
    else if (wr)
    begin
      case (addr)
        REG_CTRL: zeroPower_reg <= wdata[CTRL_ZEROPWR];
        REG_SETUP: setup_reg <= wdata;
        REG_GAIN: gain_reg <= wdata;
        REG_TXDATA: txData_reg <= wdata;
        REG_EVEN: evEnable_reg <= wdata;
        default: ;
      endcase
    end
  end

  // A new request in the cycle it is taken wins over the take.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dataValid_reg <= 1'b0;
      startReq_reg <= 1'b0;
      stopReq_reg <= 1'b0;
    end
    else
    begin
      dataValid_reg <= (wr && addr == REG_TXDATA) ||
        (dataValid_reg && !byteTaken);
      startReq_reg <= (wrCtrl && wdata[CTRL_START]) ||
        (startReq_reg && !startTaken);
      stopReq_reg <= (wrCtrl && wdata[CTRL_STOP]) ||
        (stopReq_reg && !stopTaken);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit sequencer.

  seq_state_t state;
  seq_state_t retState;
  logic [18:0] wakeCnt;
  logic [7:0] flags_reg;
  logic ringLevel_reg;
  logic [7:0] evSet;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= S_IDLE;
      retState <= S_IDLE;
      xferStart <= 1'b0;
      xferAddr <= 8'h00;
      xferData <= 8'h00;
      wakeCnt <= 19'h0;
      flags_reg <= 8'h00;
      ringLevel_reg <= 1'b0;
      byteTaken <= 1'b0;
      startTaken <= 1'b0;
      stopTaken <= 1'b0;
      evSet <= 8'h00;
    end
    else
    begin
      xferStart <= 1'b0;
      byteTaken <= 1'b0;
      startTaken <= 1'b0;
      stopTaken <= 1'b0;
      evSet <= 8'h00;
      case (state)
        S_IDLE:
        begin
          wakeCnt <= 19'h0;
          if (startReq_reg)
          begin
            startTaken <= 1'b1;
            xferStart <= 1'b1;
            xferAddr <= DEV_SETUP;
            xferData <= setup_reg;
            retState <= S_WAKE;
            state <= S_XFER;
          end
        end
        S_WAKE:
        begin
          // Leaving zero power needs the full settling wait first.
          if (!zeroPower_reg || wakeCnt >= 19'(WakeCycles - 1))
          begin
            state <= S_GAIN;
          end
          else
          begin
            wakeCnt <= wakeCnt + 19'h1;
          end
        end
        S_GAIN:
        begin
          xferStart <= 1'b1;
          xferAddr <= DEV_GAIN;
          xferData <= gain_reg;
          retState <= S_FIRST;
          state <= S_XFER;
        end
        S_FIRST:
        begin
          if (dataValid_reg)
          begin
            byteTaken <= 1'b1;
            xferStart <= 1'b1;
            xferAddr <= DEV_TXBYTE;
            xferData <= txData_reg;
            retState <= S_CLEAR;
            state <= S_XFER;
          end
        end
        S_CLEAR:
        begin
          xferStart <= 1'b1;
          xferAddr <= DEV_FLAGS;
          xferData <= 8'h00;
          retState <= S_MASK;
          state <= S_XFER;
        end
        S_MASK:
        begin
          xferStart <= 1'b1;
          xferAddr <= DEV_MASK;
          xferData <= MASK_TX;
          retState <= S_ENABLE;
          state <= S_XFER;
        end
        S_ENABLE:
        begin
          xferStart <= 1'b1;
          xferAddr <= DEV_TXMODE;
          xferData <= TXMODE_ON;
          retState <= S_WAIT;
          state <= S_XFER;
        end
        S_WAIT:
        begin
          if (stopReq_reg)
          begin
            stopTaken <= 1'b1;
            evSet[EV_STOPPED] <= 1'b1;
            xferStart <= 1'b1;
            xferAddr <= DEV_TXMODE;
            xferData <= TXMODE_OFF;
            retState <= S_IDLE;
            state <= S_XFER;
          end
          else if (!irqSync_b)
          begin
            // The read both reveals the cause and drops the interrupt.
            xferStart <= 1'b1;
            xferAddr <= DEV_FLAGS;
            xferData <= 8'h00;
            retState <= S_EVAL;
            state <= S_XFER;
          end
        end
        S_EVAL:
        begin
          flags_reg <= rxShift;
          evSet[EV_UNDERFLOW] <= rxShift[FLAG_UNDERFLOW];
          if (rxShift[FLAG_RINGCHG])
          begin
            xferStart <= 1'b1;
            xferAddr <= DEV_TONES;
            xferData <= 8'h00;
            retState <= S_TONES;
            state <= S_XFER;
          end
          else
          begin
            state <= S_READY;
          end
        end
        S_TONES:
        begin
          ringLevel_reg <= rxShift[TONE_RING];
          state <= S_READY;
        end
        S_READY:
        begin
          state <= flags_reg[FLAG_TXREADY] ? S_LOAD : S_WAIT;
        end
        S_LOAD:
        begin
          // Without data the modem sends mark; flags wait until we return.
          if (stopReq_reg)
          begin
            state <= S_WAIT;
          end
          else if (dataValid_reg)
          begin
            byteTaken <= 1'b1;
            evSet[EV_TAKEN] <= 1'b1;
            xferStart <= 1'b1;
            xferAddr <= DEV_TXBYTE;
            xferData <= txData_reg;
            retState <= S_WAIT;
            state <= S_XFER;
          end
        end
        S_XFER:
        begin
          if (xferDone)
          begin
            state <= retState;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Ring timing in milliseconds while the ring-present bit last read high.
  // Resolution is limited by how often the flags are polled.

  logic [15:0] msCnt;
  logic [15:0] ringCnt;
  logic [15:0] ringTime_reg;
  logic ringPrev;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      msCnt <= 16'h0;
      ringCnt <= 16'h0;
      ringTime_reg <= 16'h0;
      ringPrev <= 1'b0;
    end
    else
    begin
      ringPrev <= ringLevel_reg;
      if (msCnt >= 16'(MsCycles - 1))
      begin
        msCnt <= 16'h0;
      end
      else
      begin
        msCnt <= msCnt + 16'h1;
      end
      if (ringPrev && !ringLevel_reg)
      begin
        ringTime_reg <= ringCnt;
        ringCnt <= 16'h0;
      end
      else if (ringLevel_reg && msCnt == 16'h0 && ringCnt != 16'hffff)
      begin
        ringCnt <= ringCnt + 16'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Events, interrupt and read port.

  logic [7:0] events_reg;
  logic [7:0] evAll;
  logic [7:0] evClr;

  assign evAll = {evSet[7:3], ringPrev && !ringLevel_reg, evSet[1:0]};
  assign evClr = (wr && addr == REG_EVCLR) ? wdata : 8'h00;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      events_reg <= 8'h00;
    end
    else
    begin
      events_reg <= (events_reg & ~evClr) | evAll;
    end
  end

  assign irq = |(events_reg & evEnable_reg);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata <= 8'h00;
    end
    else if (rd)
    begin
      case (addr)
        REG_CTRL: rdata <= {5'h0, zeroPower_reg, stopReq_reg, startReq_reg};
        REG_SETUP: rdata <= setup_reg;
        REG_GAIN: rdata <= gain_reg;
        REG_TXDATA: rdata <= txData_reg;
        REG_STATUS: rdata <= {4'h0, ringLevel_reg, dataValid_reg, busy,
          state != S_IDLE};
        REG_EVENTS: rdata <= events_reg;
        REG_EVEN: rdata <= evEnable_reg;
        REG_RINGTIME: rdata <= ringTime_reg[7:0];
        default: rdata <= 8'h00;
      endcase
    end
    else
    begin
      rdata <= 8'h00;
    end
  end

endmodule

// >>> tb/psk_tx_host_asserts.sv
// Port-level checker for the PSK transmit host controller.
// Assumes it is bound onto psk_tx_host and sees only its ports.
module psk_tx_host_asserts
  #(
    parameter int WakeCycles = 20, // zero-power wait
    parameter int MsCycles = 10 // ring timer tick
  )
  (
    input wire logic clk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic [3:0] addr, // register index
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [7:0] rdata, // read data
    input wire logic irq, // interrupt
    input wire psk_tx_host_pkg::link_out_t linkOut, // link outputs
    input wire logic replyData, // link reply
    input wire logic interrupt_request_low // modem interrupt
  );
  import psk_tx_host_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [7:0] lowCnt;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      lowCnt <= 8'h00;
    else if (linkOut.selectLow)
      lowCnt <= 8'h00;
    else
      lowCnt <= lowCnt + 8'h01;
  sequence clkHigh4;
    linkOut.serialClk [*4] ##1 !linkOut.serialClk;
  endsequence
  sequence firstLow4;
    !linkOut.serialClk [*4] ##1 linkOut.serialClk;
  endsequence
  sequence bitHeld;
    $stable(linkOut.cmdData) [*7];
  endsequence
  AST_RDATA_ZERO: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  AST_FRAME_LEN: assert property ($rose(linkOut.selectLow)
    |-> lowCnt inside {[8'd128:8'd129]})
    else $error("frame not sixteen bits long");
  AST_IDLE_CLK: assert property (linkOut.selectLow |-> !linkOut.serialClk)
    else $error("serial clock moves outside a frame");
  AST_HIGH_PHASE: assert property ($rose(linkOut.serialClk) |-> clkHigh4)
    else $error("serial clock high phase wrong");
  AST_FIRST_LOW: assert property ($fell(linkOut.selectLow) |-> firstLow4)
    else $error("first low phase wrong");
  AST_DATA_EDGE: assert property ($changed(linkOut.cmdData)
    && !linkOut.selectLow && $past(!linkOut.selectLow)
    |-> $fell(linkOut.serialClk))
    else $error("link data changed off the falling clock");
  AST_FIRST_BIT: assert property ($fell(linkOut.selectLow) |=> bitHeld)
    else $error("first link bit not held eight cycles");
  AST_MASK_OFF: assert property (wr && addr == REG_EVEN && wdata == 8'h00
    |=> !irq)
    else $error("interrupt high with all events disabled");
endmodule

bind psk_tx_host psk_tx_host_asserts
  #(.WakeCycles(WakeCycles), .MsCycles(MsCycles)) chk
  (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .irq(irq), .linkOut(linkOut),
   .replyData(replyData),
   .interrupt_request_low(interrupt_request_low));

// >>> tb/psk_modem_model.sv
// Behavioural modem: serial registers, byte pacing, flags and ring input.
// Assumes it shares the host clock and finds link clock edges with it.
module psk_modem_model
  #(
    parameter int BytePeriod = 1500 // one less than the cycles per sent byte
  )
  (
    input wire logic clk, // clock
    input wire logic rst_b, // reset, active low
    input wire psk_tx_host_pkg::link_out_t linkIn, // host link pins
    input wire logic ringIn, // ring sense with timing node low
    output logic replyData, // serial reply
    output logic interrupt_request_low // interrupt, active low
  );
  import psk_tx_host_pkg::*;
  logic [7:0] setupReg, gainReg, byteReg, modeReg, maskReg;
  logic [7:0] flags, tones, outByte, setF;
  logic [15:0] sh;
  logic [4:0] cnt;
  logic prevClk, prevSel, loaded, lastBit, markOut, flagsRead, orderOk, clr;
  int tmr;
  // Band bits sit in the setup byte here; their places are arbitrary.
  localparam int TxBand = 1;
  localparam int RxBand = 0;
  logic eqBypass;
  // Equal bands share one equaliser need, so both are skipped.
  assign eqBypass = setupReg[TxBand] == setupReg[RxBand];
  // A deselected reply line shows the last reply bit inverted.
  assign replyData = linkIn.selectLow ? ~lastBit : lastBit;
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      {setupReg, gainReg, byteReg, modeReg, maskReg, flags} <= '0;
      {sh, cnt, prevClk, loaded, lastBit, markOut, flagsRead} <= '0;
      {prevSel, orderOk, interrupt_request_low} <= 3'h7;
      tones <= 8'h80;
      outByte <= 8'h00;
      tmr <= 0;
    end
    else
    begin
      setF = 8'h00;
      clr = 1'b0;
      prevClk <= linkIn.serialClk;
      prevSel <= linkIn.selectLow;
      if (linkIn.selectLow)
        cnt <= 5'h00;
      else if (linkIn.serialClk && !prevClk)
      begin
        sh <= {sh[14:0], linkIn.cmdData};
        cnt <= cnt + 5'h01;
        if (cnt == 5'h07)
          outByte <= {sh[6:0], linkIn.cmdData} == DEV_FLAGS ? flags : tones;
        if (cnt == 5'h07 && {sh[6:0], linkIn.cmdData} == DEV_FLAGS)
        begin
          clr = 1'b1;
          flagsRead <= 1'b1;
        end
      end
      else if (!linkIn.serialClk && prevClk && cnt >= 5'h08)
      begin
        lastBit <= outByte[7];
        outByte <= {outByte[6:0], 1'b0};
      end
      if (modeReg[0])
      begin
        tmr <= tmr == BytePeriod ? 0 : tmr + 1;
        if (tmr == BytePeriod)
        begin
          setF[FLAG_TXREADY] = 1'b1;
          setF[FLAG_UNDERFLOW] = !loaded;
          markOut <= !loaded;
          loaded <= 1'b0;
        end
      end
      else
        tmr <= 0;
      if (linkIn.selectLow && !prevSel && cnt == 5'h10)
        case (sh[15:8])
          DEV_SETUP: setupReg <= sh[7:0];
          DEV_GAIN: gainReg <= sh[7:0];
          DEV_TXBYTE:
          begin
            byteReg <= sh[7:0];
            loaded <= 1'b1;
            markOut <= 1'b0;
          end
          DEV_TXMODE:
          begin
            modeReg <= sh[7:0];
            if (sh[0] && !loaded)
              orderOk <= 1'b0;
          end
          DEV_MASK:
          begin
            maskReg <= sh[7:0];
            if (!flagsRead)
              orderOk <= 1'b0;
          end
          default: ;
        endcase
      if (ringIn != tones[TONE_RING])
        setF[FLAG_RINGCHG] = 1'b1;
      tones[TONE_RING] <= ringIn;
      flags <= (clr ? 8'h00 : flags) | setF;
      if (|(setF & ~flags & maskReg))
        interrupt_request_low <= 1'b0;
      else if (clr)
        interrupt_request_low <= 1'b1;
    end
endmodule

// >>> tb/psk_tx_host_test.sv
// Self-checking bench for the PSK transmit host controller.
// Assumes the modem model on the link and register tasks on the port.
module psk_tx_host_test;
  timeunit 1ns;
  timeprecision 1ns;
  import psk_tx_host_pkg::*;
  logic clk, rst_b, wr, rd, ringIn, replyData, modemIrqLow, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  link_out_t linkOut;
  int n_mismatch, checks_done, i;
  psk_tx_host #(.WakeCycles(20), .MsCycles(10)) uut
    (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
     .rd(rd), .rdata(rdata), .irq(irq), .linkOut(linkOut),
     .replyData(replyData), .interrupt_request_low(modemIrqLow));
  psk_modem_model #(.BytePeriod(1500)) modem
    (.clk(clk), .rst_b(rst_b), .linkIn(linkOut), .ringIn(ringIn),
     .replyData(replyData), .interrupt_request_low(modemIrqLow));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Reads until a masked bit shows; a spent bound ends the run.
  task automatic poll(input logic [3:0] a, input logic [7:0] m);
    int k;
    for (k = 0; k < 4000; k++)
    begin
      rd_reg(a, d);
      if ((d & m) != 8'h00)
        break;
    end
    check("poll", d & m, m);
    if (k == 4000)
      stop_test();
  endtask
  initial
  begin
    {addr, wdata, wr, rd, ringIn, rst_b} = '0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(REG_STATUS, d);
    check("status", d, 8'h00);
    rd_reg(REG_EVENTS, d);
    check("events", d, 8'h00);
    rd_reg(4'hf, d);
    check("unmapped", d, 8'h00);
    rd_reg(REG_SETUP, d);
    check("setup", d, SETUP_RESET);
    $display("test reset done");
    wr_reg(REG_SETUP, 8'h5a);
    wr_reg(REG_GAIN, 8'h3c);
    wr_reg(REG_TXDATA, 8'ha5);
    wr_reg(REG_EVEN, 8'h0f);
    rd_reg(REG_GAIN, d);
    check("gain rd", d, 8'h3c);
    rd_reg(REG_EVEN, d);
    check("enable rd", d, 8'h0f);
    wr_reg(REG_CTRL, 8'h05);
    for (i = 0; i < 3000 && modem.modeReg !== TXMODE_ON; i++)
      @(posedge clk);
    check("setup", modem.setupReg, 8'h5a);
    check("gain", modem.gainReg, 8'h3c);
    check("first", modem.byteReg, 8'ha5);
    check("mask", modem.maskReg, MASK_TX);
    check("order", {7'h00, modem.orderOk}, 8'h01);
    check("mode", modem.modeReg, TXMODE_ON);
    check("bypass", {7'h00, modem.eqBypass}, 8'h00);
    if (i == 3000)
      stop_test();
    $display("test start done");
    wr_reg(REG_TXDATA, 8'h96);
    poll(REG_EVENTS, 8'h01);
    // The event shows as the frame starts; the byte lands a frame later.
    repeat (140) @(posedge clk);
    check("next", modem.byteReg, 8'h96);
    check("irq", {7'h00, irq}, 8'h01);
    check("dev irq", {7'h00, modemIrqLow}, 8'h01);
    wr_reg(REG_EVEN, 8'h00);
    check("masked", {7'h00, irq}, 8'h00);
    wr_reg(REG_EVEN, 8'h0f);
    wr_reg(REG_EVCLR, 8'hff);
    check("cleared", {7'h00, irq}, 8'h00);
    $display("test refill done");
    for (i = 0; i < 4000 && modem.markOut !== 1'b1; i++)
      @(posedge clk);
    check("mark", {7'h00, modem.markOut}, 8'h01);
    if (i == 4000)
      stop_test();
    ringIn <= 1'b1;
    wr_reg(REG_TXDATA, 8'h3c);
    poll(REG_EVENTS, 8'h02);
    check("unmark", {7'h00, modem.markOut}, 8'h00);
    check("late", modem.byteReg, 8'h3c);
    poll(REG_STATUS, 8'h08);
    ringIn <= 1'b0;
    wr_reg(REG_TXDATA, 8'h69);
    poll(REG_EVENTS, 8'h04);
    $display("test underflow done");
    wr_reg(REG_CTRL, 8'h02);
    poll(REG_EVENTS, 8'h08);
    repeat (140) @(posedge clk);
    check("off", modem.modeReg, TXMODE_OFF);
    wr_reg(REG_EVCLR, 8'hff);
    rd_reg(REG_EVENTS, d);
    check("events", d, 8'h00);
    check("irq", {7'h00, irq}, 8'h00);
    $display("test stop done");
    stop_test();
  end
endmodule
